// ### rtl/usps_consts.vh
// register map, field positions and reset values of the pipe status block
`ifndef USPS_CONSTS_VH
`define USPS_CONSTS_VH
// register indices; byte address is four times the index
`define USPS_IDX_FLAG 9'h060
`define USPS_IDX_EVT 9'h062
`define USPS_IDX_MASK 9'h064
`define USPS_IDX_CTRL 9'h066
`define USPS_IDX_DMXPS 9'h068
`define USPS_IDX_PID 9'h06A
`define USPS_IDX_ADDR 9'h076
`define USPS_IDX_REQ0 9'h078
`define USPS_IDX_REQ1 9'h07A
`define USPS_IDX_REQ2 9'h07C
`define USPS_IDX_REQ3 9'h07E
// control register fields
`define USPS_CTRL_SCLK 0
`define USPS_CTRL_SRST 1
`define USPS_CTRL_DIR_LO 2
`define USPS_CTRL_DIR_HI 5
// event register fields
`define USPS_EVT_SETUP 0
`define USPS_EVT_ADDR 1
// reset values
`define USPS_RST_FLAG 4'h0
`define USPS_RST_EVT 2'h0
`define USPS_RST_MASK 6'h00
`define USPS_RST_CTRL 6'h00
`define USPS_RST_DMXPS 7'h40
`define USPS_RST_PID 8'h00
`define USPS_RST_ADDR 7'h00
`define USPS_RST_REQ 16'h0000
// request decode
`define USPS_REQ_SET_ADDR 8'h05
`define USPS_TYPE_STD_DEV 8'h00
// response codes
`define USPS_PID_STALL 2'h2
`define USPS_RESP_OKAY 2'h0
`define USPS_RESP_SLVERR 2'h2
`endif

// ### rtl/usps_top.v
// pipe status flags, device address and setup capture with an AXI4-Lite slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "usps_consts.vh"
module usps_top #(
  parameter PIPE_MXPS = 11'd512, // max packet size, pipes 1-3
  parameter LEN_W = 11 // packet length width
) (
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  // axi4-lite write address
  input wire [11:0] S_AXI_AWADDR_IN,
  input wire S_AXI_AWVALID_IN,
  output wire S_AXI_AWREADY_OUT,
  // axi4-lite write data
  input wire [31:0] S_AXI_WDATA_IN,
  input wire [3:0] S_AXI_WSTRB_IN,
  input wire S_AXI_WVALID_IN,
  output wire S_AXI_WREADY_OUT,
  // axi4-lite write response
  output wire [1:0] S_AXI_BRESP_OUT,
  output wire S_AXI_BVALID_OUT,
  input wire S_AXI_BREADY_IN,
  // axi4-lite read address
  input wire [11:0] S_AXI_ARADDR_IN,
  input wire S_AXI_ARVALID_IN,
  output wire S_AXI_ARREADY_OUT,
  // axi4-lite read data
  output wire [31:0] S_AXI_RDATA_OUT,
  output wire [1:0] S_AXI_RRESP_OUT,
  output wire S_AXI_RVALID_OUT,
  input wire S_AXI_RREADY_IN,
  // usb side events
  input wire USB_BUS_RST_IN,
  input wire [3:0] TX_EMPTY_IN,
  input wire RX_END_IN,
  input wire [1:0] RX_PIPE_IN,
  input wire [LEN_W-1:0] RX_LEN_IN,
  input wire SETUP_VALID_IN,
  input wire [63:0] SETUP_DATA_IN,
  input wire STATUS_DONE_IN,
  // outputs to the rest of the controller
  output wire [7:0] PIPE_RESP_OUT,
  output wire [6:0] DEV_ADDR_OUT,
  output wire SET_ADDR_AUTO_OUT,
  output wire IRQ_OUT
);

  // max packet size for one pipe; index 0 is the control pipe
  function [LEN_W-1:0] pipe_max;
    input [1:0] idx;
    input [6:0] dmxps;
    begin
      if (idx == 2'd0)
      begin
        pipe_max = {{(LEN_W-7){1'b0}}, dmxps};
      end
      else
      begin
        pipe_max = PIPE_MXPS[LEN_W-1:0];
      end
    end
  endfunction

  // register index match on a byte address
  function idx_hit;
    input [11:0] addr;
    input [8:0] idx;
    begin
      idx_hit = (addr[10:2] == idx) && (addr[1:0] == 2'b00) && !addr[11];
    end
  endfunction

  // --- bus slave state ---
  reg aw_hold_ff; // write address taken
  reg w_hold_ff; // write data taken
  reg [11:0] awaddr_ff; // latched write address
  reg [31:0] wdata_ff; // latched write data
  reg [3:0] wstrb_ff; // latched byte strobes
  reg bvalid_ff; // write response pending
  reg [1:0] bresp_ff; // write response code
  reg rvalid_ff; // read data pending
  reg [1:0] rresp_ff; // read response code
  reg [31:0] rdata_ff; // read data

  // --- block state ---
  reg [3:0] flag_ff; // empty/overrun flags, bit 0 control pipe
  reg [1:0] evt_ff; // sticky events, cleared by read
  reg [5:0] mask_ff; // interrupt enables {evt, flag}
  reg [5:0] ctrl_ff; // dir[5:2], soft reset, clock supply
  reg soft_rst_ff; // one-cycle soft reset
  reg [6:0] dmxps_ff; // control pipe max packet size
  reg [7:0] pid_ff; // 2-bit response code per pipe
  reg [6:0] addr_ff; // device bus address
  reg [6:0] addr_pend_ff; // address waiting for status stage
  reg pend_ff; // set-address in progress
  reg [15:0] req0_ff; // request and request type
  reg [15:0] req1_ff; // value word
  reg [15:0] req2_ff; // index word
  reg [15:0] req3_ff; // length word

  // --- combinational terms ---
  wire aw_fire; // write address handshake
  wire w_fire; // write data handshake
  wire ar_fire; // read address handshake
  wire wr_go; // register write this cycle
  wire wr_map; // write address is mapped
  wire wr_lo; // low byte lane written
  wire wr_hi; // high byte lane written
  wire sclk_on; // internal clock supplied
  wire clr_all; // soft reset pulse
  wire cap_clr; // soft or bus reset
  wire [3:0] dir_in; // pipe direction, 1 = IN
  wire [3:0] flag_set; // flag events this cycle
  wire [3:0] ovr_set; // oversize events this cycle
  wire [3:0] flag_clr; // software clears this cycle
  wire is_set_addr; // setup holds set-address
  wire rd_evt; // read of event register
  reg [31:0] rd_mux; // read data select
  reg rd_ok; // read address mapped

  // handshakes; one transfer per channel at a time
  assign S_AXI_AWREADY_OUT = !aw_hold_ff && !bvalid_ff;
  assign S_AXI_WREADY_OUT = !w_hold_ff && !bvalid_ff;
  assign S_AXI_ARREADY_OUT = !rvalid_ff;
  assign aw_fire = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
  assign w_fire = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  assign ar_fire = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_lo = wr_go && wstrb_ff[0];
  assign wr_hi = wr_go && wstrb_ff[1];

  // response outputs straight from flops
  assign S_AXI_BVALID_OUT = bvalid_ff;
  assign S_AXI_BRESP_OUT = bresp_ff;
  assign S_AXI_RVALID_OUT = rvalid_ff;
  assign S_AXI_RRESP_OUT = rresp_ff;
  assign S_AXI_RDATA_OUT = rdata_ff;

  // control decode
  assign sclk_on = ctrl_ff[`USPS_CTRL_SCLK];
  assign dir_in = ctrl_ff[`USPS_CTRL_DIR_HI:`USPS_CTRL_DIR_LO];
  assign clr_all = soft_rst_ff;
  assign cap_clr = soft_rst_ff || USB_BUS_RST_IN;
  assign rd_evt = ar_fire && idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_EVT);

  // mapped writable or read-only targets
  assign wr_map = idx_hit(awaddr_ff, `USPS_IDX_FLAG)
    || idx_hit(awaddr_ff, `USPS_IDX_EVT)
    || idx_hit(awaddr_ff, `USPS_IDX_MASK)
    || idx_hit(awaddr_ff, `USPS_IDX_CTRL)
    || idx_hit(awaddr_ff, `USPS_IDX_DMXPS)
    || idx_hit(awaddr_ff, `USPS_IDX_PID)
    || idx_hit(awaddr_ff, `USPS_IDX_ADDR)
    || idx_hit(awaddr_ff, `USPS_IDX_REQ0)
    || idx_hit(awaddr_ff, `USPS_IDX_REQ1)
    || idx_hit(awaddr_ff, `USPS_IDX_REQ2)
    || idx_hit(awaddr_ff, `USPS_IDX_REQ3);

  // per-pipe set and clear terms
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pipe
      // oversize packet on an OUT pipe
      assign ovr_set[gi] = RX_END_IN && (RX_PIPE_IN == gi) && !dir_in[gi]
        && (RX_LEN_IN > pipe_max(gi, dmxps_ff));
      // drained buffers on an IN pipe, or oversize
      assign flag_set[gi] = (TX_EMPTY_IN[gi] && dir_in[gi])
        || ovr_set[gi];
      // zero written with clock supplied; ones ignored
      assign flag_clr[gi] = wr_lo && idx_hit(awaddr_ff, `USPS_IDX_FLAG)
        && sclk_on && !wdata_ff[gi];
    end
  endgenerate

  // standard device request to set the address
  assign is_set_addr = (SETUP_DATA_IN[7:0] == `USPS_TYPE_STD_DEV)
    && (SETUP_DATA_IN[15:8] == `USPS_REQ_SET_ADDR);

  // block outputs
  assign PIPE_RESP_OUT = pid_ff;
  assign DEV_ADDR_OUT = addr_ff;
  assign SET_ADDR_AUTO_OUT = pend_ff;
  assign IRQ_OUT = |({evt_ff, flag_ff} & mask_ff);

  // write channel capture and response
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `USPS_RESP_OKAY;
    end
    else
    begin
      // address may arrive before or after data
      if (aw_fire)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR_IN;
      end
      if (w_fire)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA_IN;
        wstrb_ff <= S_AXI_WSTRB_IN;
      end
      // both held: apply and answer
      if (wr_go)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? `USPS_RESP_OKAY : `USPS_RESP_SLVERR;
      end
      else if (bvalid_ff && S_AXI_BREADY_IN)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read data select
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_FLAG))
      rd_mux = {28'h0000000, flag_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_EVT))
      rd_mux = {30'h00000000, evt_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_MASK))
      rd_mux = {26'h0000000, mask_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_CTRL))
      rd_mux = {26'h0000000, ctrl_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_DMXPS))
      rd_mux = {25'h0000000, dmxps_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_PID))
      rd_mux = {24'h000000, pid_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_ADDR))
      rd_mux = {25'h0000000, addr_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_REQ0))
      rd_mux = {16'h0000, req0_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_REQ1))
      rd_mux = {16'h0000, req1_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_REQ2))
      rd_mux = {16'h0000, req2_ff};
    else if (idx_hit(S_AXI_ARADDR_IN, `USPS_IDX_REQ3))
      rd_mux = {16'h0000, req3_ff};
    else
      rd_ok = 1'b0;
  end

  // read channel
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `USPS_RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end
    else if (ar_fire)
    begin
      // unmapped reads answer zero with an error
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_ok ? `USPS_RESP_OKAY : `USPS_RESP_SLVERR;
      rdata_ff <= rd_mux;
    end
    else if (rvalid_ff && S_AXI_RREADY_IN)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  // empty/overrun flags
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      flag_ff <= `USPS_RST_FLAG;
    end
    else if (clr_all)
    begin
      flag_ff <= `USPS_RST_FLAG;
    end
    else
    begin
      // set wins over a clear in the same cycle
      flag_ff <= (flag_ff & ~flag_clr) | flag_set;
    end
  end

  // sticky events, cleared by reading them
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      evt_ff <= `USPS_RST_EVT;
    end
    else if (clr_all)
    begin
      evt_ff <= `USPS_RST_EVT;
    end
    else
    begin
      // a new event beats the read clear
      evt_ff <= (rd_evt ? 2'b00 : evt_ff)
        | {pend_ff && STATUS_DONE_IN, SETUP_VALID_IN};
    end
  end

  // software control registers
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      mask_ff <= `USPS_RST_MASK;
      ctrl_ff <= `USPS_RST_CTRL;
      soft_rst_ff <= 1'b0;
      dmxps_ff <= `USPS_RST_DMXPS;
    end
    else if (clr_all)
    begin
      mask_ff <= `USPS_RST_MASK;
      ctrl_ff <= `USPS_RST_CTRL;
      soft_rst_ff <= 1'b0;
      dmxps_ff <= `USPS_RST_DMXPS;
    end
    else
    begin
      // soft reset is a write-one pulse
      soft_rst_ff <= wr_lo && idx_hit(awaddr_ff, `USPS_IDX_CTRL)
        && wdata_ff[`USPS_CTRL_SRST];
      if (wr_lo && idx_hit(awaddr_ff, `USPS_IDX_MASK))
        mask_ff <= wdata_ff[5:0];
      if (wr_lo && idx_hit(awaddr_ff, `USPS_IDX_CTRL))
        ctrl_ff <= {wdata_ff[5:2], 1'b0, wdata_ff[0]};
      if (wr_lo && idx_hit(awaddr_ff, `USPS_IDX_DMXPS))
        dmxps_ff <= wdata_ff[6:0];
    end
  end

  // per-pipe response codes, forced to stall on oversize
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      pid_ff <= `USPS_RST_PID;
    end
    else if (clr_all)
    begin
      pid_ff <= `USPS_RST_PID;
    end
    else
    begin
      if (wr_lo && idx_hit(awaddr_ff, `USPS_IDX_PID))
        pid_ff <= wdata_ff[7:0];
      // stall wins over a software write
      if (ovr_set[0])
        pid_ff[1:0] <= `USPS_PID_STALL;
      if (ovr_set[1])
        pid_ff[3:2] <= `USPS_PID_STALL;
      if (ovr_set[2])
        pid_ff[5:4] <= `USPS_PID_STALL;
      if (ovr_set[3])
        pid_ff[7:6] <= `USPS_PID_STALL;
    end
  end

  // device address, loaded only at status stage end
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      addr_ff <= `USPS_RST_ADDR;
      addr_pend_ff <= `USPS_RST_ADDR;
      pend_ff <= 1'b0;
    end
    else if (cap_clr)
    begin
      addr_ff <= `USPS_RST_ADDR;
      addr_pend_ff <= `USPS_RST_ADDR;
      pend_ff <= 1'b0;
    end
    else if (SETUP_VALID_IN)
    begin
      // a new setup replaces any pending request
      pend_ff <= is_set_addr;
      addr_pend_ff <= SETUP_DATA_IN[22:16];
    end
    else if (pend_ff && STATUS_DONE_IN)
    begin
      // bus writes never reach this register
      addr_ff <= addr_pend_ff;
      pend_ff <= 1'b0;
    end
  end

  // setup stage capture, read only from the bus
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      req0_ff <= `USPS_RST_REQ;
      req1_ff <= `USPS_RST_REQ;
      req2_ff <= `USPS_RST_REQ;
      req3_ff <= `USPS_RST_REQ;
    end
    else if (cap_clr)
    begin
      req0_ff <= `USPS_RST_REQ;
      req1_ff <= `USPS_RST_REQ;
      req2_ff <= `USPS_RST_REQ;
      req3_ff <= `USPS_RST_REQ;
    end
    else if (SETUP_VALID_IN)
    begin
      // only the usb side loads these
      req0_ff <= SETUP_DATA_IN[15:0];
      req1_ff <= SETUP_DATA_IN[31:16];
      req2_ff <= SETUP_DATA_IN[47:32];
      req3_ff <= SETUP_DATA_IN[63:48];
    end
  end

endmodule

// ### tb/usps_properties.sv
// checker for the pipe status block, bound to its top
`timescale 1ns/1ps
`include "usps_consts.vh"
module usps_properties #(
  parameter PIPE_MXPS = 11'd512,
  parameter LEN_W = 11
) (
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire [11:0] S_AXI_AWADDR_IN,
  input wire S_AXI_AWVALID_IN,
  input wire S_AXI_AWREADY_OUT,
  input wire [31:0] S_AXI_WDATA_IN,
  input wire S_AXI_WVALID_IN,
  input wire S_AXI_WREADY_OUT,
  input wire S_AXI_BVALID_OUT,
  input wire [11:0] S_AXI_ARADDR_IN,
  input wire S_AXI_ARVALID_IN,
  input wire S_AXI_ARREADY_OUT,
  input wire [31:0] S_AXI_RDATA_OUT,
  input wire S_AXI_RVALID_OUT,
  input wire USB_BUS_RST_IN,
  input wire RX_END_IN,
  input wire [1:0] RX_PIPE_IN,
  input wire [LEN_W-1:0] RX_LEN_IN,
  input wire SETUP_VALID_IN,
  input wire [63:0] SETUP_DATA_IN,
  input wire STATUS_DONE_IN,
  input wire [7:0] PIPE_RESP_OUT,
  input wire [6:0] DEV_ADDR_OUT,
  input wire SET_ADDR_AUTO_OUT,
  input wire IRQ_OUT
);
  localparam [11:0] A_CTRL = {1'b0, `USPS_IDX_CTRL, 2'b00};
  localparam [11:0] A_ADDR = {1'b0, `USPS_IDX_ADDR, 2'b00};
  localparam [11:0] A_REQ0 = {1'b0, `USPS_IDX_REQ0, 2'b00};
  reg [11:0] rd_a_ff; // read in flight
  reg [11:0] wr_a_ff; // write in flight
  reg srst_ff; // write data asks soft reset
  reg bv_ff; // response valid last cycle
  reg [15:0] cap_ff; // expected first capture
  reg [6:0] pend_ff; // address awaiting status stage
  // track bus traffic and expected capture contents
  always @(posedge REF_CLK_IN)
  begin
    bv_ff <= S_AXI_BVALID_OUT;
    if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
      rd_a_ff <= S_AXI_ARADDR_IN;
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      wr_a_ff <= S_AXI_AWADDR_IN;
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      srst_ff <= S_AXI_WDATA_IN[`USPS_CTRL_SRST];
    if (!RST_N_IN || USB_BUS_RST_IN || (S_AXI_BVALID_OUT && !bv_ff && srst_ff
        && wr_a_ff == A_CTRL))
      cap_ff <= 16'h0000;
    else if (SETUP_VALID_IN)
      cap_ff <= SETUP_DATA_IN[15:0];
    if (SETUP_VALID_IN && SETUP_DATA_IN[15:0] == 16'h0500)
      pend_ff <= SETUP_DATA_IN[22:16];
  end
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  AST_RST_CLEAR:
    assert property (disable iff (1'b0) !RST_N_IN |=> DEV_ADDR_OUT == 7'h00
      && PIPE_RESP_OUT == 8'h00 && !IRQ_OUT)
    else $error("outputs not cleared by reset");
  AST_BUS_RST:
    assert property (USB_BUS_RST_IN |=> DEV_ADDR_OUT == 7'h00 && !SET_ADDR_AUTO_OUT)
    else $error("bus reset left address");
  AST_SETUP_PEND:
    assert property (SETUP_VALID_IN && SETUP_DATA_IN[15:0] == 16'h0500
      && !USB_BUS_RST_IN |=> SET_ADDR_AUTO_OUT)
    else $error("set-address not pending");
  AST_ADDR_LOAD:
    assert property (STATUS_DONE_IN && SET_ADDR_AUTO_OUT && !SETUP_VALID_IN
      && !USB_BUS_RST_IN |=> DEV_ADDR_OUT == pend_ff && !SET_ADDR_AUTO_OUT)
    else $error("address not loaded at status stage");
  AST_ADDR_CAUSE:
    assert property ($changed(DEV_ADDR_OUT) && DEV_ADDR_OUT != 7'h00
      |-> $past(STATUS_DONE_IN) && $past(SET_ADDR_AUTO_OUT))
    else $error("address changed without status stage");
  AST_STALL_CAUSE:
    assert property ($rose(PIPE_RESP_OUT[3]) && !$rose(S_AXI_BVALID_OUT)
      |-> $past(RX_END_IN) && $past(RX_PIPE_IN) == 2'h1 && $past(RX_LEN_IN) > PIPE_MXPS)
    else $error("pipe 1 stalled without oversize");
  AST_ADDR_RSV:
    assert property (S_AXI_RVALID_OUT && rd_a_ff == A_ADDR
      |-> S_AXI_RDATA_OUT[31:7] == 25'h0)
    else $error("address upper bits not zero");
  AST_CAP_REQ0:
    assert property (S_AXI_RVALID_OUT && rd_a_ff == A_REQ0
      |-> S_AXI_RDATA_OUT[15:0] == cap_ff)
    else $error("request capture wrong");
endmodule
bind usps_top usps_properties #(.PIPE_MXPS(PIPE_MXPS), .LEN_W(LEN_W)) u_usps_properties (.*);

// ### tb/usps_host_model.sv
// behavioural usb host driving the event inputs
`timescale 1ns/1ps
module usps_host_model (
  input wire clk_in,
  output reg bus_rst_out,
  output reg [3:0] tx_empty_out,
  output reg rx_end_out,
  output reg [1:0] rx_pipe_out,
  output reg [10:0] rx_len_out,
  output reg setup_valid_out,
  output reg [63:0] setup_data_out,
  output reg status_done_out
);
  // idle levels
  initial
  begin
    bus_rst_out = 1'b0;
    tx_empty_out = 4'h0;
    rx_end_out = 1'b0;
    rx_pipe_out = 2'h0;
    rx_len_out = 11'h000;
    setup_valid_out = 1'b0;
    setup_data_out = 64'h0;
    status_done_out = 1'b0;
  end
  // buffers of one pipe drained
  task drain(input [1:0] p);
  begin
    tx_empty_out <= 4'h1 << p;
    @(posedge clk_in);
    tx_empty_out <= 4'h0;
    @(posedge clk_in);
  end
  endtask
  // out packet ends; qualifiers scrambled once released
  task rx(input [1:0] p, input [10:0] len);
  begin
    rx_pipe_out <= p;
    rx_len_out <= len;
    rx_end_out <= 1'b1;
    @(posedge clk_in);
    rx_end_out <= 1'b0;
    rx_pipe_out <= ~p;
    rx_len_out <= ~len;
    @(posedge clk_in);
  end
  endtask
  // setup packet received
  task setup(input [63:0] d);
  begin
    setup_data_out <= d;
    setup_valid_out <= 1'b1;
    @(posedge clk_in);
    setup_valid_out <= 1'b0;
    setup_data_out <= ~d;
    @(posedge clk_in);
  end
  endtask
  // bus reset when b is high, else status stage done
  task strobe(input b);
  begin
    bus_rst_out <= b;
    status_done_out <= !b;
    @(posedge clk_in);
    bus_rst_out <= 1'b0;
    status_done_out <= 1'b0;
    @(posedge clk_in);
  end
  endtask
endmodule

// ### tb/usps_top_tb.sv
// self-checking bench for the pipe status block
`timescale 1ns/1ps
`include "usps_consts.vh"
module usps_top_tb;
  localparam [10:0] MX = 11'h200; // pipes 1-3 max packet
  reg clk, rst_n, awv, wv, arv;
  reg brdy, rrdy; // response ready levels, raised per transfer
  reg [3:0] ws; // write byte strobes
  reg [11:0] awa, ara;
  reg [31:0] wd;
  reg [63:0] sdr;
  reg [10:0] len;
  wire awr, wrr, bv, arr, rv, brst, rxe, sv, sd, pend, irq;
  wire [1:0] bresp, rresp, rxp;
  wire [31:0] rdat;
  wire [3:0] txe;
  wire [10:0] rxl;
  wire [63:0] sdat;
  wire [7:0] resp;
  wire [6:0] dadr;
  integer num_errors, cmp_count, seed, m_flag, i;
  usps_top #(.PIPE_MXPS(MX), .LEN_W(11)) u_usps_top (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrr), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(brdy), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rrdy), .USB_BUS_RST_IN(brst),
    .TX_EMPTY_IN(txe), .RX_END_IN(rxe), .RX_PIPE_IN(rxp), .RX_LEN_IN(rxl),
    .SETUP_VALID_IN(sv), .SETUP_DATA_IN(sdat), .STATUS_DONE_IN(sd),
    .PIPE_RESP_OUT(resp), .DEV_ADDR_OUT(dadr), .SET_ADDR_AUTO_OUT(pend), .IRQ_OUT(irq));
  usps_host_model u_usps_host_model (.clk_in(clk), .bus_rst_out(brst), .tx_empty_out(txe),
    .rx_end_out(rxe), .rx_pipe_out(rxp), .rx_len_out(rxl), .setup_valid_out(sv),
    .setup_data_out(sdat), .status_done_out(sd));
  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare one result
  task chk(input [31:0] g, input [31:0] e);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      num_errors = num_errors + 1;
    end
  end
  endtask
  // one write, response code checked
  task wr(input [8:0] x, input [31:0] d, input [1:0] er = 2'h0);
    integer n;
    reg ta, tw, got;
    reg [1:0] br;
  begin
    n = 0;
    got = 1'b0;
    br = 2'h3;
    awa <= {1'b0, x, 2'b00};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!got && n < 50)
    begin
      // handshakes judged mid-cycle, as the next edge will see them
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrr;
      got = bv && brdy;
      br = bresp;
      @(posedge clk);
      if (ta)
        awv <= 1'b0;
      if (tw)
        wv <= 1'b0;
      if (!got)
        brdy <= 1'b1;
      n = n + 1;
    end
    brdy <= 1'b0;
    chk({30'h0, br}, {30'h0, er});
  end
  endtask
  // one read, data and response checked
  task rd(input [8:0] x, input [31:0] e, input [1:0] er = 2'h0);
    integer n;
    reg ta, got;
    reg [31:0] dd;
    reg [1:0] rr;
  begin
    n = 0;
    got = 1'b0;
    dd = 32'hFFFFFFFF;
    rr = 2'h3;
    ara <= {1'b0, x, 2'b00};
    arv <= 1'b1;
    while (!got && n < 50)
    begin
      // data taken at the edge where rvalid and rready meet
      @(negedge clk);
      ta = arv && arr;
      got = rv && rrdy;
      dd = rdat;
      rr = rresp;
      @(posedge clk);
      if (ta)
        arv <= 1'b0;
      if (!got)
        rrdy <= 1'b1;
      n = n + 1;
    end
    rrdy <= 1'b0;
    chk(dd, e);
    chk({30'h0, rr}, {30'h0, er});
  end
  endtask
  // interrupt level seen mid-cycle
  task chk_irq(input e);
  begin
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  end
  endtask
  // address then four captures
  function [8:0] ro_idx(input integer k);
  begin
    ro_idx = (k == 0) ? `USPS_IDX_ADDR : `USPS_IDX_REQ0 + 9'(2 * k - 2);
  end
  endfunction
  task report_and_stop;
  begin
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // watchdog
  initial
  begin
    #400000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
  initial
  begin
    seed = 51;
    num_errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    awv = 1'b0;
    wv = 1'b0;
    arv = 1'b0;
    brdy = 1'b0;
    rrdy = 1'b0;
    ws = 4'hF;
    awa = 12'h000;
    ara = 12'h000;
    wd = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // read-only places ignore writes, unmapped refused
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(ro_idx(i), 32'hFFFF);
      rd(ro_idx(i), 32'h0);
    end
    rd(9'h1FF, 32'h0, `USPS_RESP_SLVERR);
    wr(9'h1FF, 32'h1, `USPS_RESP_SLVERR);
    $display("test read-only done");
    // random setup packet into all captures
    sdr = {$random(seed), $random(seed)};
    sdr[15:8] = 8'h06;
    u_usps_host_model.setup(sdr);
    for (i = 1; i < 5; i = i + 1)
      rd(ro_idx(i), {16'h0, sdr[16*i-16 +: 16]});
    rd(`USPS_IDX_EVT, 32'h1);
    $display("test capture done");
    // set-address waits for status stage
    wr(`USPS_IDX_MASK, 32'h10);
    u_usps_host_model.setup(64'h0000_0000_0023_0500);
    rd(`USPS_IDX_ADDR, 32'h0);
    chk_irq(1'b1);
    u_usps_host_model.strobe(1'b0);
    rd(`USPS_IDX_ADDR, 32'h23);
    chk({25'h0, dadr}, 32'h23);
    rd(`USPS_IDX_EVT, 32'h3);
    chk_irq(1'b0);
    $display("test address done");
    // drains on in pipes 0 and 2, oversize on out pipes 1 and 3
    wr(`USPS_IDX_CTRL, 32'h15);
    m_flag = 0;
    for (i = 0; i < 4; i = i + 1)
    begin
      len = MX + 11'h001 + 11'({$random(seed)} % 16);
      u_usps_host_model.drain(i[1:0]);
      u_usps_host_model.rx(i[1:0], MX);
      u_usps_host_model.rx(i[1:0], len);
      m_flag = m_flag | (1 << i);
    end
    rd(`USPS_IDX_FLAG, m_flag);
    chk({24'h0, resp}, 32'h88);
    wr(`USPS_IDX_MASK, 32'h1);
    chk_irq(1'b1);
    wr(`USPS_IDX_FLAG, 32'hF);
    rd(`USPS_IDX_FLAG, m_flag);
    wr(`USPS_IDX_CTRL, 32'h14);
    wr(`USPS_IDX_FLAG, 32'h0);
    rd(`USPS_IDX_FLAG, m_flag);
    wr(`USPS_IDX_CTRL, 32'h15);
    fork
      wr(`USPS_IDX_FLAG, 32'hE);
      begin
        @(posedge clk);
        u_usps_host_model.drain(2'h0);
      end
    join
    rd(`USPS_IDX_FLAG, m_flag);
    wr(`USPS_IDX_FLAG, 32'h9);
    m_flag = 9;
    rd(`USPS_IDX_FLAG, m_flag);
    wr(`USPS_IDX_FLAG, 32'h8);
    wr(`USPS_IDX_FLAG, 32'h0);
    rd(`USPS_IDX_FLAG, 32'h0);
    chk_irq(1'b0);
    // control pipe out oversize
    wr(`USPS_IDX_CTRL, 32'h11);
    u_usps_host_model.rx(2'h0, 11'h040);
    u_usps_host_model.rx(2'h0, 11'h041);
    rd(`USPS_IDX_FLAG, 32'h1);
    chk({30'h0, resp[1:0]}, {30'h0, `USPS_PID_STALL});
    chk_irq(1'b1);
    $display("test flags done");
    // soft and bus resets
    wr(`USPS_IDX_CTRL, 32'h2);
    rd(`USPS_IDX_ADDR, 32'h0);
    rd(`USPS_IDX_REQ0, 32'h0);
    chk_irq(1'b0);
    u_usps_host_model.setup(sdr);
    u_usps_host_model.strobe(1'b1);
    rd(`USPS_IDX_REQ1, 32'h0);
    $display("test resets done");
    report_and_stop;
  end
endmodule
